// ### src/hssc_defs.svh
// constants of the transceiver configuration register block
`ifndef HSSC_DEFS_SVH
`define HSSC_DEFS_SVH

// -----------------------------------------------------------------------------
// bus widths
// -----------------------------------------------------------------------------
`define HSSC_AW             8
`define HSSC_DW             32
`define HSSC_SW             4

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define HSSC_IDX_GLOBAL     6'h01
`define HSSC_IDX_PLL        6'h02
`define HSSC_IDX_TXRX       6'h03
`define HSSC_IDX_STAT       6'h06

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define HSSC_PLL_RST        16'h831d
`define HSSC_TXRX_RST       16'ha848
`define HSSC_GLOBAL_RST     16'h0000

// -----------------------------------------------------------------------------
// field positions of the pll register
// -----------------------------------------------------------------------------
`define HSSC_PLL_RSV_HI     15:10
`define HSSC_PLL_BW         9:8
`define HSSC_PLL_RSV7       7
`define HSSC_PLL_VCO_LOW    6
`define HSSC_PLL_RSV5       5
`define HSSC_PLL_ON         4
`define HSSC_PLL_MULT       3:0

// -----------------------------------------------------------------------------
// field positions of the transmit and receive register
// -----------------------------------------------------------------------------
`define HSSC_TR_AMPL        15:12
`define HSSC_TR_TX_ON       11
`define HSSC_TR_EQ_FREEZE   10
`define HSSC_TR_TX_RATE     9:8
`define HSSC_TR_GAIN        7:6
`define HSSC_TR_AZCAL       5:4
`define HSSC_TR_RX_ON       3
`define HSSC_TR_RX_RATE     2:0

// -----------------------------------------------------------------------------
// global and status fields
// -----------------------------------------------------------------------------
`define HSSC_GLOBAL_OFF     15
`define HSSC_STAT_W         4

// -----------------------------------------------------------------------------
// bus responses
// -----------------------------------------------------------------------------
`define HSSC_RESP_OKAY      2'h0
`define HSSC_RESP_SLVERR    2'h2

`endif

// ### src/hssc_pkg.sv
// types shared by the transceiver configuration register block
package hssc_pkg;
   typedef logic [31:0] hssc_word_t;
   typedef logic [15:0] hssc_reg16_t;
   typedef logic [7:0]  hssc_addr_t;
   typedef logic [3:0]  hssc_strb_t;
   typedef logic [1:0]  hssc_resp_t;

   typedef enum logic [2:0] {SEL_NONE, SEL_GLOBAL, SEL_PLL, SEL_TXRX, SEL_STAT} hssc_sel_e;

   typedef struct packed {
      hssc_reg16_t pll_cfg;
      hssc_reg16_t txrx_cfg;
      logic        global_off;
      logic        aw_held;
      hssc_addr_t  aw_addr;
      logic        w_held;
      hssc_word_t  w_data;
      hssc_strb_t  w_strb;
      logic        b_valid;
      hssc_resp_t  b_resp;
      logic        r_valid;
      hssc_word_t  r_data;
      hssc_resp_t  r_resp;
      logic        wr_seen;
   } hssc_main_s;

   typedef struct packed {
      logic s1;
      logic s2;
   } hssc_sync_s;

   typedef struct packed {
      logic pll_en;
      logic tx_en;
      logic rx_en;
   } hssc_gate_s;
endpackage : hssc_pkg

// ### src/hssc_pin_sync.sv
// two-stage synchroniser for the transceiver power-down pin
`timescale 1ns/1ps
module hssc_pin_sync
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin_async,
   output logic      pin_sync
);
   import hssc_pkg::*;

   hssc_sync_s q_r;
   hssc_sync_s q_nxt;

   // only the second stage is read
   always_comb
   begin
      q_nxt    = q_r;
      q_nxt.s1 = pin_async;
      q_nxt.s2 = q_r.s1;
   end

   // resets to "powered down" so nothing is enabled before the pin is seen
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign pin_sync = q_r.s2;
endmodule : hssc_pin_sync

// ### src/hssc_power_gate.sv
// effective enables of pll, transmitter and receiver
`timescale 1ns/1ps
module hssc_power_gate
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pll_on,
   input  wire logic transmitter_on,
   input  wire logic receiver_on,
   input  wire logic pin_up,
   input  wire logic global_off,
   output logic      pll_en,
   output logic      tx_en,
   output logic      rx_en
);
   import hssc_pkg::*;

   hssc_gate_s q_r;
   hssc_gate_s q_nxt;
   logic       powered;

   assign powered = pin_up && !global_off;

   always_comb
   begin
      q_nxt        = q_r;
      q_nxt.pll_en = pll_on && powered;
      q_nxt.tx_en  = transmitter_on && powered;
      q_nxt.rx_en  = receiver_on && powered;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign pll_en = q_r.pll_en;
   assign tx_en  = q_r.tx_en;
   assign rx_en  = q_r.rx_en;
endmodule : hssc_power_gate

// ### src/hssc_regs.sv
// transceiver configuration registers behind an axi4-lite slave
// How it works
// - pll register bits 15:10 reset to 100000 and stay writable
// - pll loop bandwidth at bits 9:8, four settings, resets to 11
// - bit 6 picks vco range, zero upper end, resets to zero
// - pll on bit resets one; pll off when bit, pin or global off say so
// - pll multiplier at bits 3:0 resets to 1101, reserved codes kept as written
// - transmit amplitude at bits 15:12 resets to 1010, sixteen swing steps
// - transmitter on bit 11 resets one; gated by pin and global off
// - bit 10 freezes equalizer and long-tail correction, resets to zero
// - transmit rate divider at bits 9:8, resets to full rate
// - gain loop control at bits 7:6 resets to 01
// - auto-zero calibration mode at bits 5:4 resets to 00
// - receiver on bit 3 resets one; gated by pin and global off
// - receive rate divider at bits 2:0 resets to 000, reserved codes kept
// - pll register bits 7 and 5 reset to zero and stay writable
// - global off stops the datapath while registers stay reachable
`timescale 1ns/1ps
`include "hssc_defs.svh"
module hssc_regs
(
   input  wire logic              MCLK,
   input  wire logic              NRST,
   input  wire logic              TRANSCEIVER_GLOBAL_POWER_OFF_N,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire hssc_pkg::hssc_addr_t AWADDR,
   input  wire logic              WVALID,
   output logic                   WREADY,
   input  wire hssc_pkg::hssc_word_t WDATA,
   input  wire hssc_pkg::hssc_strb_t WSTRB,
   output logic                   BVALID,
   input  wire logic              BREADY,
   output hssc_pkg::hssc_resp_t   BRESP,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   input  wire hssc_pkg::hssc_addr_t ARADDR,
   output logic                   RVALID,
   input  wire logic              RREADY,
   output hssc_pkg::hssc_word_t   RDATA,
   output hssc_pkg::hssc_resp_t   RRESP,
   output logic [1:0]             PLL_LOOP_BW_SEL,
   output logic                   VCO_LOW_RANGE_SEL,
   output logic [3:0]             PLL_MULTIPLIER,
   output logic                   PLL_ON_EFF,
   output logic [3:0]             TX_OUTPUT_AMPLITUDE,
   output logic                   TX_ON_EFF,
   output logic                   EQUALIZER_FREEZE,
   output logic [1:0]             TRANSMIT_RATE_DIVIDER,
   output logic [1:0]             GAIN_LOOP_CONTROL,
   output logic [1:0]             AUTOZERO_CAL_MODE,
   output logic                   RX_ON_EFF,
   output logic [2:0]             RECEIVE_RATE_DIVIDER,
   output logic                   GLOBAL_POWER_OFF
);
   import hssc_pkg::*;

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   hssc_main_s q_r;
   hssc_main_s q_nxt;
   hssc_sel_e  sel_w;
   hssc_sel_e  sel_r;
   logic       pin_up;
   logic       aw_ready;
   logic       w_ready;
   logic       ar_ready;
   logic       wr_fire;

   // -------------------------------------------------------------------------
   // functions
   // -------------------------------------------------------------------------
   function automatic hssc_sel_e decode(input hssc_addr_t addr);
      if (addr == {`HSSC_IDX_GLOBAL, 2'h0})
         decode = SEL_GLOBAL;
      else if (addr == {`HSSC_IDX_PLL, 2'h0})
         decode = SEL_PLL;
      else if (addr == {`HSSC_IDX_TXRX, 2'h0})
         decode = SEL_TXRX;
      else if (addr == {`HSSC_IDX_STAT, 2'h0})
         decode = SEL_STAT;
      else
         decode = SEL_NONE;
   endfunction : decode

   // only the two low byte lanes carry register bits
   function automatic hssc_reg16_t merge16(input hssc_reg16_t old,
                                           input hssc_word_t  d,
                                           input hssc_strb_t  s);
      merge16 = old;
      if (s[0])
         merge16[7:0] = d[7:0];
      if (s[1])
         merge16[15:8] = d[15:8];
   endfunction : merge16

   function automatic hssc_word_t widen16(input hssc_reg16_t v);
      widen16 = {16'h0000, v};
   endfunction : widen16

   // -------------------------------------------------------------------------
   // pin synchroniser and power gating
   // -------------------------------------------------------------------------
   hssc_pin_sync u_pin_sync
   (
      .clk       (MCLK),
      .rst_n     (NRST),
      .pin_async (TRANSCEIVER_GLOBAL_POWER_OFF_N),
      .pin_sync  (pin_up)
   );

   hssc_power_gate u_power_gate
   (
      .clk            (MCLK),
      .rst_n          (NRST),
      .pll_on         (q_r.pll_cfg[`HSSC_PLL_ON]),
      .transmitter_on (q_r.txrx_cfg[`HSSC_TR_TX_ON]),
      .receiver_on    (q_r.txrx_cfg[`HSSC_TR_RX_ON]),
      .pin_up         (pin_up),
      .global_off     (q_r.global_off),
      .pll_en         (PLL_ON_EFF),
      .tx_en          (TX_ON_EFF),
      .rx_en          (RX_ON_EFF)
   );

   // -------------------------------------------------------------------------
   // bus handshakes
   // -------------------------------------------------------------------------
   // one write in flight: address and data are parked until the write fires, and no new ones are taken until the response leaves
   assign aw_ready = !q_r.aw_held && !q_r.b_valid;
   assign w_ready  = !q_r.w_held && !q_r.b_valid;
   assign ar_ready = !q_r.r_valid;
   assign wr_fire  = q_r.aw_held && q_r.w_held && !q_r.b_valid;
   assign sel_w    = decode(q_r.aw_addr);
   assign sel_r    = decode(ARADDR);

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      q_nxt = q_r;
      if (AWVALID && aw_ready)
      begin
         q_nxt.aw_held = 1'b1;
         q_nxt.aw_addr = AWADDR;
      end
      if (WVALID && w_ready)
      begin
         q_nxt.w_held = 1'b1;
         q_nxt.w_data = WDATA;
         q_nxt.w_strb = WSTRB;
      end
      if (wr_fire)
      begin
         q_nxt.aw_held = 1'b0;
         q_nxt.w_held  = 1'b0;
         q_nxt.b_valid = 1'b1;
         q_nxt.b_resp  = `HSSC_RESP_OKAY;
         q_nxt.wr_seen = 1'b1;
         // reserved fields and codes are stored as written
         case (sel_w)
            SEL_PLL:
               q_nxt.pll_cfg = merge16(q_r.pll_cfg, q_r.w_data, q_r.w_strb);
            SEL_TXRX:
               q_nxt.txrx_cfg = merge16(q_r.txrx_cfg, q_r.w_data, q_r.w_strb);
            SEL_GLOBAL:
            begin
               if (q_r.w_strb[1])
                  q_nxt.global_off = q_r.w_data[`HSSC_GLOBAL_OFF];
            end
            default:
               q_nxt.b_resp = `HSSC_RESP_SLVERR;
         endcase
      end
      else if (q_r.b_valid && BREADY)
      begin
         q_nxt.b_valid = 1'b0;
      end
      // read acceptance never looks at the power state, so reads work while powered off
      if (ARVALID && ar_ready)
      begin
         q_nxt.r_valid = 1'b1;
         q_nxt.r_resp  = `HSSC_RESP_OKAY;
         case (sel_r)
            SEL_PLL:
               q_nxt.r_data = widen16(q_r.pll_cfg);
            SEL_TXRX:
               q_nxt.r_data = widen16(q_r.txrx_cfg);
            SEL_GLOBAL:
               q_nxt.r_data = widen16({q_r.global_off, 15'h0000});
            SEL_STAT:
               q_nxt.r_data = {28'h0000000, pin_up, PLL_ON_EFF, TX_ON_EFF, RX_ON_EFF};
            default:
            begin
               q_nxt.r_data = '0;
               q_nxt.r_resp = `HSSC_RESP_SLVERR;
            end
         endcase
      end
      else if (q_r.r_valid && RREADY)
      begin
         q_nxt.r_valid = 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         q_r            <= '0;
         q_r.pll_cfg    <= `HSSC_PLL_RST;
         q_r.txrx_cfg   <= `HSSC_TXRX_RST;
         q_r.global_off <= 1'b0;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   assign AWREADY = aw_ready;
   assign WREADY  = w_ready;
   assign ARREADY = ar_ready;
   assign BVALID  = q_r.b_valid;
   assign BRESP   = q_r.b_resp;
   assign RVALID  = q_r.r_valid;
   assign RDATA   = q_r.r_data;
   assign RRESP   = q_r.r_resp;

   assign PLL_LOOP_BW_SEL       = q_r.pll_cfg[`HSSC_PLL_BW];
   assign VCO_LOW_RANGE_SEL     = q_r.pll_cfg[`HSSC_PLL_VCO_LOW];
   assign PLL_MULTIPLIER        = q_r.pll_cfg[`HSSC_PLL_MULT];
   assign TX_OUTPUT_AMPLITUDE   = q_r.txrx_cfg[`HSSC_TR_AMPL];
   assign EQUALIZER_FREEZE      = q_r.txrx_cfg[`HSSC_TR_EQ_FREEZE];
   assign TRANSMIT_RATE_DIVIDER = q_r.txrx_cfg[`HSSC_TR_TX_RATE];
   assign GAIN_LOOP_CONTROL     = q_r.txrx_cfg[`HSSC_TR_GAIN];
   assign AUTOZERO_CAL_MODE     = q_r.txrx_cfg[`HSSC_TR_AZCAL];
   assign RECEIVE_RATE_DIVIDER  = q_r.txrx_cfg[`HSSC_TR_RX_RATE];
   assign GLOBAL_POWER_OFF      = q_r.global_off;

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   sequence s_pll_write;
      wr_fire && sel_w == SEL_PLL && q_r.w_strb[1:0] == 2'b11;
   endsequence

   sequence s_txrx_write;
      wr_fire && sel_w == SEL_TXRX && q_r.w_strb[1:0] == 2'b11;
   endsequence

   property p_pll_defaults;
      @(posedge MCLK) disable iff (!NRST)
      !q_r.wr_seen |-> (q_r.pll_cfg[`HSSC_PLL_RSV_HI] == 6'h20
                        && PLL_LOOP_BW_SEL == 2'h3 && !VCO_LOW_RANGE_SEL
                        && !q_r.pll_cfg[`HSSC_PLL_RSV7] && !q_r.pll_cfg[`HSSC_PLL_RSV5]
                        && q_r.pll_cfg[`HSSC_PLL_ON] && PLL_MULTIPLIER == 4'hd);
   endproperty
   a_pll_defaults: assert property (p_pll_defaults)
      else $error("pll register left its reset value before any write");

   property p_txrx_defaults;
      @(posedge MCLK) disable iff (!NRST)
      !q_r.wr_seen |-> (TX_OUTPUT_AMPLITUDE == 4'ha && q_r.txrx_cfg[`HSSC_TR_TX_ON]
                        && !EQUALIZER_FREEZE && TRANSMIT_RATE_DIVIDER == 2'h0
                        && GAIN_LOOP_CONTROL == 2'h1 && AUTOZERO_CAL_MODE == 2'h0
                        && q_r.txrx_cfg[`HSSC_TR_RX_ON] && RECEIVE_RATE_DIVIDER == 3'h0);
   endproperty
   a_txrx_defaults: assert property (p_txrx_defaults)
      else $error("transmit and receive register left its reset value before any write");

   property p_pll_readback;
      @(posedge MCLK) disable iff (!NRST)
      s_pll_write |=> (q_r.pll_cfg == $past(q_r.w_data[15:0]))
                      && BVALID && BRESP == `HSSC_RESP_OKAY;
   endproperty
   a_pll_readback: assert property (p_pll_readback)
      else $error("pll register does not hold the written word");

   property p_txrx_readback;
      @(posedge MCLK) disable iff (!NRST)
      s_txrx_write ##1 (!q_r.aw_held && !q_r.w_held)
         |-> TX_OUTPUT_AMPLITUDE == $past(q_r.w_data[15:12])
             && RECEIVE_RATE_DIVIDER == $past(q_r.w_data[2:0]);
   endproperty
   a_txrx_readback: assert property (p_txrx_readback)
      else $error("transmit and receive fields do not follow the written word");

   property p_pll_gate;
      @(posedge MCLK) disable iff (!NRST)
      PLL_ON_EFF == ($past(q_r.pll_cfg[`HSSC_PLL_ON]) && $past(pin_up) && !$past(q_r.global_off));
   endproperty
   a_pll_gate: assert property (p_pll_gate)
      else $error("pll enable does not match bit, pin and global off");

   property p_tx_gate;
      @(posedge MCLK) disable iff (!NRST)
      TX_ON_EFF |-> $past(q_r.txrx_cfg[`HSSC_TR_TX_ON]) && $past(pin_up)
                    && !$past(q_r.global_off);
   endproperty
   a_tx_gate: assert property (p_tx_gate)
      else $error("transmitter enabled while a disable condition held");

   property p_rx_gate;
      @(posedge MCLK) disable iff (!NRST)
      (q_r.txrx_cfg[`HSSC_TR_RX_ON] && pin_up && !q_r.global_off) |=> RX_ON_EFF;
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("receiver not enabled one cycle after all conditions held");

   property p_global_off;
      @(posedge MCLK) disable iff (!NRST)
      q_r.global_off |=> !PLL_ON_EFF && !TX_ON_EFF && !RX_ON_EFF;
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("datapath still enabled under global power off");

   property p_read_when_off;
      @(posedge MCLK) disable iff (!NRST)
      (ARVALID && ARREADY && sel_r == SEL_PLL) |=> RVALID && RRESP == `HSSC_RESP_OKAY
                                                   && RDATA[15:0] == $past(q_r.pll_cfg);
   endproperty
   a_read_when_off: assert property (p_read_when_off)
      else $error("register read did not return the stored value next cycle");

   property p_pin_off;
      @(posedge MCLK) disable iff (!NRST)
      !TRANSCEIVER_GLOBAL_POWER_OFF_N [*3] |=> !PLL_ON_EFF && !TX_ON_EFF && !RX_ON_EFF;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("enables did not drop after the power-down pin went low");
endmodule : hssc_regs

// ### testbench/hssc_mgmt_master.sv
// management master model driving the axi4-lite register port
`timescale 1ns/1ps
module hssc_mgmt_master
#(
   parameter int REFCLK_MHZ = 156
)
(
   input  wire logic             mclk,
   output logic                  awvalid,
   input  wire logic             awready,
   output hssc_pkg::hssc_addr_t  awaddr,
   output logic                  wvalid,
   input  wire logic             wready,
   output hssc_pkg::hssc_word_t  wdata,
   output hssc_pkg::hssc_strb_t  wstrb,
   input  wire logic             bvalid,
   output logic                  bready,
   output logic                  arvalid,
   input  wire logic             arready,
   output hssc_pkg::hssc_addr_t  araddr,
   input  wire logic             rvalid,
   output logic                  rready
);
   import hssc_pkg::*;
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
   end
   // software side picks the low vco range below 2.5 ghz
   function automatic logic vco_low(input logic [3:0] m);
      int f[16] = '{0, 0, 400, 500, 600, 800, 825, 1000, 1200, 1250, 1500, 1600, 1650,
                    2000, 2500, 0};
      return REFCLK_MHZ * f[m] < 250000;
   endfunction : vco_low
   // released payloads are inverted so a stale value is never mistaken for a live one
   task automatic wr(input hssc_addr_t a, input logic [15:0] d, input hssc_strb_t s);
      int n;
      n = 0;
      @(posedge mclk);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= {~d, d};
      wstrb <= s;
      do
      begin
         @(posedge mclk);
         n++;
         if (awvalid && awready)
         begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready)
         begin
            wvalid <= 1'b0;
            wdata <= {d, ~d};
         end
      end
      while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      // the answer may still land on the last allowed edge
      if (bvalid !== 1'b1) test_hs_serdes_config_regs.hang();
   endtask : wr
   task automatic rd(input hssc_addr_t a);
      int n;
      n = 0;
      @(posedge mclk);
      {arvalid, rready} <= 2'h3;
      araddr <= a;
      do
      begin
         @(posedge mclk);
         n++;
         if (arvalid && arready)
         begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end
      while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      if (rvalid !== 1'b1) test_hs_serdes_config_regs.hang();
   endtask : rd
endmodule : hssc_mgmt_master

// ### testbench/test_hs_serdes_config_regs.sv
// self-checking bench of the transceiver configuration registers
`timescale 1ns/1ps
module test_hs_serdes_config_regs;
   import hssc_pkg::*;
   localparam logic [15:0] PLL_RST = {6'b100000, 2'b11, 3'b000, 1'b1, 4'b1101};
   localparam logic [15:0] TR_RST = {4'b1010, 2'b10, 2'b00, 2'b01, 2'b00, 1'b1, 3'b000};
   localparam hssc_resp_t OK = 2'h0, SE = 2'h2;
   logic mclk = 1'b0, nrst = 1'b0, pin_n = 1'b1;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   hssc_addr_t awaddr, araddr;
   hssc_word_t wdata, rdata;
   hssc_strb_t wstrb;
   hssc_resp_t bresp, rresp;
   logic [1:0] bw, txr, gain, azc;
   logic [3:0] mult, amp;
   logic [2:0] rxr;
   logic vco, pll_eff, tx_eff, eqf, rx_eff, goff;
   int n_errors = 0, comparisons = 0;
   logic [33:0] rq[$];
   hssc_resp_t bq[$];
   logic [15:0] p, t;
   always #20 mclk = ~mclk;
   hssc_regs i_hssc_regs (.MCLK(mclk), .NRST(nrst), .TRANSCEIVER_GLOBAL_POWER_OFF_N(pin_n),
      .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
      .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
      .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
      .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
      .PLL_LOOP_BW_SEL(bw), .VCO_LOW_RANGE_SEL(vco), .PLL_MULTIPLIER(mult),
      .PLL_ON_EFF(pll_eff), .TX_OUTPUT_AMPLITUDE(amp), .TX_ON_EFF(tx_eff),
      .EQUALIZER_FREEZE(eqf), .TRANSMIT_RATE_DIVIDER(txr), .GAIN_LOOP_CONTROL(gain),
      .AUTOZERO_CAL_MODE(azc), .RX_ON_EFF(rx_eff), .RECEIVE_RATE_DIVIDER(rxr),
      .GLOBAL_POWER_OFF(goff));
   hssc_mgmt_master i_hssc_mgmt_master (.mclk(mclk), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready));
   // ---------------------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------------------
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic test_done();
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic hang();
      n_errors++;
      test_done();
   endtask : hang
   // bus answers are matched against the oldest note at the handshake edge
   always @(posedge mclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1)
         chk({rresp, rdata}, rq.pop_front());
      if (bvalid === 1'b1 && bready === 1'b1)
         chk(34'(bresp), 34'(bq.pop_front()));
   end
   task automatic rd_x(input hssc_addr_t a, input logic [15:0] d, input hssc_resp_t r);
      rq.push_back({r, 16'h0000, d});
      i_hssc_mgmt_master.rd(a);
   endtask : rd_x
   task automatic wr_x(input hssc_addr_t a, input logic [15:0] d, input hssc_strb_t s,
                       input hssc_resp_t r);
      bq.push_back(r);
      i_hssc_mgmt_master.wr(a, d, s);
   endtask : wr_x
   task automatic chk_fields(input logic [15:0] ep, input logic [15:0] et);
      @(negedge mclk);
      chk(34'({bw, vco, mult}), 34'({ep[9:8], ep[6], ep[3:0]}));
      chk(34'({amp, eqf, txr, gain, azc, rxr}), 34'({et[15:12], et[10:4], et[2:0]}));
   endtask : chk_fields
   task automatic chk_en(input logic [3:0] e);
      repeat (4) @(posedge mclk);
      #1 chk(34'({goff, pll_eff, tx_eff, rx_eff}), 34'(e));
   endtask : chk_en
   // ---------------------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------------------
   initial
   begin
      p = 16'($urandom(32'h84d4));
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      chk_fields(PLL_RST, TR_RST);
      rd_x(8'h08, PLL_RST, OK);
      rd_x(8'h0c, TR_RST, OK);
      rd_x(8'h04, 16'h0000, OK);
      chk_en(4'h7);
      for (int i = 0; i < 16; i++)
      begin
         p = 16'($urandom());
         p[3:0] = 4'(i);
         p[6] = i_hssc_mgmt_master.vco_low(p[3:0]);
         t = 16'($urandom());
         t[2:0] = 3'(i);
         wr_x(8'h08, p, 4'h3, OK);
         wr_x(8'h0c, t, 4'h3, OK);
         chk_fields(p, t);
         rd_x(8'h08, p, OK);
         rd_x(8'h0c, t, OK);
      end
      wr_x(8'h08, ~p, 4'h1, OK);
      p[7:0] = ~p[7:0];
      rd_x(8'h08, p, OK);
      for (int k = 0; k < 8; k++)
      begin
         @(posedge mclk);
         pin_n <= k[1];
         p[4] = k[0];
         t[11] = k[0];
         t[3] = k[0];
         wr_x(8'h08, p, 4'h3, OK);
         wr_x(8'h0c, t, 4'h3, OK);
         wr_x(8'h04, {k[2], 15'h0000}, 4'h2, OK);
         chk_en({k[2], {3{k[0] & k[1] & !k[2]}}});
         rd_x(8'h08, p, OK);
      end
      wr_x(8'h30, 16'hffff, 4'h3, SE);
      wr_x(8'h18, 16'hffff, 4'h3, SE);
      rd_x(8'h30, 16'h0000, SE);
      rd_x(8'h18, 16'h0008, OK);
      rd_x(8'h0c, t, OK);
      // let the watcher take the last answer before the verdict; no note may be left over
      @(negedge mclk);
      chk(34'(rq.size() + bq.size()), 34'h0);
      test_done();
   end
endmodule : test_hs_serdes_config_regs
